// ---- eeu_map.vh ----
// Constants for the exception, interrupt and trap entry unit.
`ifndef EEU_MAP_VH
`define EEU_MAP_VH

// ****************************************************************
// Vector addresses
// ****************************************************************
`define EEU_VEC_RESET 32'h00000000
`define EEU_VEC_SBREAK 32'h00000010
`define EEU_VEC_UNDEF 32'h00000020
`define EEU_VEC_ALIGN 32'h00000030
`define EEU_VEC_TRAP_BASE 32'h00000040
`define EEU_VEC_IRQ 32'h00000080
`define EEU_VEC_IRQ_FLASH 32'h00804000
`define EEU_BOOT_ADDR_DEF 32'h00000000
`define EEU_TRAP_RET_STEP 32'h00000004

// ****************************************************************
// Opcodes seen by the unit; any value above the last one is undefined
// ****************************************************************
`define EEU_OP_ALU 8'h00
`define EEU_OP_READ_HALF_SIGNED 8'h01
`define EEU_OP_READ_HALF_UNSIGNED 8'h02
`define EEU_OP_WRITE_HALF 8'h03
`define EEU_OP_READ_WORD 8'h04
`define EEU_OP_WRITE_WORD 8'h05
`define EEU_OP_LOCK 8'h06
`define EEU_OP_UNLOCK 8'h07
`define EEU_OP_TRAP 8'h08
`define EEU_OP_RETURN 8'h09
`define EEU_OP_JUMP 8'h0A
`define EEU_OP_LAST 8'h0A

// ****************************************************************
// Event codes reported on the last_event output and register
// ****************************************************************
`define EEU_EV_NONE 3'h0
`define EEU_EV_RESET 3'h1
`define EEU_EV_SBREAK 3'h2
`define EEU_EV_UNDEF 3'h3
`define EEU_EV_ALIGN 3'h4
`define EEU_EV_TRAP 3'h5
`define EEU_EV_IRQ 3'h6
`define EEU_EV_RETURN 3'h7

// ****************************************************************
// Register map (word indices on avs_address[3:2]) and field positions
// ****************************************************************
`define EEU_REG_CTRL 2'h0
`define EEU_REG_STATUS 2'h1
`define EEU_REG_SAVED_PC 2'h2
`define EEU_REG_EVENT 2'h3
`define EEU_CTRL_BOOT 0
`define EEU_CTRL_FLASH 1
`define EEU_ST_COND 0
`define EEU_ST_IE 6
`define EEU_ST_SM 7
`define EEU_ST_SAVED_COND 8
`define EEU_ST_SAVED_IE 14
`define EEU_ST_SAVED_SM 15
`define EEU_CTRL_RESET 2'h0

`endif

// ---- eeu_core.v ----
// Exception, interrupt and trap entry unit with an Avalon-MM register port.
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
// Function
// - Vectors reset 0x00, break 0x10, undef 0x20, misalign 0x30, irq 0x80.
// - Trap n vectors to 0x40+4n, keeps select, clears enable, saves pc+4.
// - Break and irq save next pc; reset clears saved pc to zero.
// - Leaving reset always vectors to 0x00: rst also clears the boot mode bit that would select BOOT_ADDR.
// - In flash write mode the irq vector moves to 0x00804000.
// - Undefined opcodes are suppressed and raise the undefined fault.
// - Undefined fault beats a simultaneous peripheral interrupt.
// - Faults copy stack select, enable and condition into backups.
// - Faults keep stack select and clear enable and condition.
// - Faults save the faulting pc; its halfword bit shows misalignment.
// - Return after a fault clears the two low pc bits.
// - Halfword accesses at low bits 01 or 11 are misaligned.
// - Word and lock accesses at low bits 01, 10 or 11 are misaligned.
// - A misaligned access is not performed.
// - Misaligned fault beats a simultaneous peripheral interrupt.
// - The vector jump is issued in the same cycle that status and pc are saved.
// - Reset, break and irq clear stack select; faults and traps keep it.
// - Return restores status bits from backups and pc from saved pc.
// - Reset has the highest priority of all events.
// - Irq accepted only at word boundaries and while enable is one.
`include "eeu_map.vh"

module eeu_core #(
    parameter [31:0] BOOT_ADDR = `EEU_BOOT_ADDR_DEF
) (
    input wire sys_clk,
    input wire rst,
    input wire instr_valid,
    input wire [31:0] instr_pc,
    input wire [31:0] instr_next_pc,
    input wire [7:0] instr_op,
    input wire [3:0] trap_num,
    input wire [1:0] mem_addr_lo,
    input wire cond_we,
    input wire cond_value,
    input wire system_break_event,
    input wire peripheral_irq,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    output reg redirect_valid,
    output reg [31:0] redirect_pc,
    output reg flush,
    output reg commit_valid,
    output reg mem_access_en,
    output reg stack_select,
    output reg irq_enable_bit,
    output reg cond_bit,
    output reg saved_stack_select,
    output reg saved_irq_enable,
    output reg saved_condition,
    output reg [31:0] saved_pc,
    output reg [2:0] last_event
);

    // ************************************************************
    // Decode functions
    // ************************************************************

    // Returns one for a halfword access opcode.
    function is_half;
        input [7:0] op;
        begin
            is_half = (op == `EEU_OP_READ_HALF_SIGNED) ||
                (op == `EEU_OP_READ_HALF_UNSIGNED) ||
                (op == `EEU_OP_WRITE_HALF);
        end
    endfunction

    // Returns one for a word or lock access opcode.
    function is_word;
        input [7:0] op;
        begin
            is_word = (op == `EEU_OP_READ_WORD) ||
                (op == `EEU_OP_WRITE_WORD) ||
                (op == `EEU_OP_LOCK) || (op == `EEU_OP_UNLOCK);
        end
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    reg [1:0] ctrl;
    reg reset_pending;
    reg sbreak_pending;
    reg ret_clear_low;
    reg [2:0] ev;
    reg [31:0] vec;
    reg [31:0] next_saved_pc;
    reg next_sm;
    reg next_ie;
    reg next_c;
    reg do_save;
    reg do_fault;
    wire take;
    wire undef_op;
    wire misaligned;
    wire word_break;
    wire bus_req;
    wire bus_done;
    wire [31:0] status_rd;

    // Younger instructions after a redirect are ignored.
    assign take = instr_valid && !redirect_valid;
    assign undef_op = instr_op > `EEU_OP_LAST;
    assign misaligned = (is_half(instr_op) && mem_addr_lo[0]) ||
        (is_word(instr_op) && (mem_addr_lo != 2'h0));
    assign word_break = instr_next_pc[1:0] == 2'h0;
    assign bus_req = avs_read || avs_write;
    assign bus_done = bus_req && !avs_waitrequest;
    assign status_rd = ({31'h0, cond_bit} << `EEU_ST_COND) |
        ({31'h0, irq_enable_bit} << `EEU_ST_IE) |
        ({31'h0, stack_select} << `EEU_ST_SM) |
        ({31'h0, saved_condition} << `EEU_ST_SAVED_COND) |
        ({31'h0, saved_irq_enable} << `EEU_ST_SAVED_IE) |
        ({31'h0, saved_stack_select} << `EEU_ST_SAVED_SM);

    // ************************************************************
    // Event selection and priority
    // ************************************************************

    // Picks one event; reset first, then faults ahead of interrupts.
    always @* begin
        ev = `EEU_EV_NONE;
        vec = 32'h00000000;
        next_saved_pc = saved_pc;
        next_sm = stack_select;
        next_ie = irq_enable_bit;
        next_c = cond_bit;
        do_save = 1'b0;
        do_fault = 1'b0;
        if (reset_pending) begin
            ev = `EEU_EV_RESET;
            vec = ctrl[`EEU_CTRL_BOOT] ? BOOT_ADDR : `EEU_VEC_RESET;
            next_sm = 1'b0;
            next_ie = 1'b0;
            next_c = 1'b0;
        end else if (take && undef_op) begin
            ev = `EEU_EV_UNDEF;
            vec = `EEU_VEC_UNDEF;
            do_fault = 1'b1;
        end else if (take && misaligned) begin
            ev = `EEU_EV_ALIGN;
            vec = `EEU_VEC_ALIGN;
            do_fault = 1'b1;
        end else if (take && instr_op == `EEU_OP_TRAP) begin
            ev = `EEU_EV_TRAP;
            vec = `EEU_VEC_TRAP_BASE + {26'h0, trap_num, 2'h0};
            do_save = 1'b1;
            next_saved_pc = instr_pc + `EEU_TRAP_RET_STEP;
            next_ie = 1'b0;
            next_c = 1'b0;
        end else if (take && instr_op == `EEU_OP_RETURN) begin
            ev = `EEU_EV_RETURN;
            vec = ret_clear_low ? {saved_pc[31:2], 2'h0} : saved_pc;
            next_sm = saved_stack_select;
            next_ie = saved_irq_enable;
            next_c = saved_condition;
        end else if (take && word_break && sbreak_pending) begin
            ev = `EEU_EV_SBREAK;
            vec = `EEU_VEC_SBREAK;
            do_save = 1'b1;
            next_saved_pc = instr_next_pc;
            next_sm = 1'b0;
            next_ie = 1'b0;
            next_c = 1'b0;
        end else if (take && word_break && peripheral_irq &&
                irq_enable_bit) begin
            ev = `EEU_EV_IRQ;
            vec = ctrl[`EEU_CTRL_FLASH] ? `EEU_VEC_IRQ_FLASH :
                `EEU_VEC_IRQ;
            do_save = 1'b1;
            next_saved_pc = instr_next_pc;
            next_sm = 1'b0;
            next_ie = 1'b0;
            next_c = 1'b0;
        end else if (take && cond_we) begin
            next_c = cond_value;
        end
        if (do_fault) begin
            do_save = 1'b1;
            next_saved_pc = instr_pc;
            next_ie = 1'b0;
            next_c = 1'b0;
        end
    end

    // ************************************************************
    // Status word, saved pc and redirect
    // ************************************************************

    // Hardware events win over a software write in the same cycle.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reset_pending <= 1'b1;
            stack_select <= 1'b0;
            irq_enable_bit <= 1'b0;
            cond_bit <= 1'b0;
            saved_stack_select <= 1'b0;
            saved_irq_enable <= 1'b0;
            saved_condition <= 1'b0;
            saved_pc <= 32'h00000000;
            ret_clear_low <= 1'b0;
            redirect_valid <= 1'b0;
            redirect_pc <= 32'h00000000;
            flush <= 1'b0;
            commit_valid <= 1'b0;
            mem_access_en <= 1'b0;
            last_event <= `EEU_EV_NONE;
        end else begin
            reset_pending <= 1'b0;
            redirect_valid <= ev != `EEU_EV_NONE;
            redirect_pc <= vec;
            flush <= ev != `EEU_EV_NONE;
            commit_valid <= take && (ev == `EEU_EV_NONE ||
                ev == `EEU_EV_SBREAK || ev == `EEU_EV_IRQ ||
                ev == `EEU_EV_TRAP || ev == `EEU_EV_RETURN);
            mem_access_en <= take && ev == `EEU_EV_NONE &&
                (is_half(instr_op) || is_word(instr_op));
            if (ev != `EEU_EV_NONE) begin
                last_event <= ev;
            end
            if (bus_done && avs_write &&
                    avs_address[3:2] == `EEU_REG_STATUS) begin
                cond_bit <= avs_writedata[`EEU_ST_COND];
                irq_enable_bit <= avs_writedata[`EEU_ST_IE];
                stack_select <= avs_writedata[`EEU_ST_SM];
                saved_condition <= avs_writedata[`EEU_ST_SAVED_COND];
                saved_irq_enable <= avs_writedata[`EEU_ST_SAVED_IE];
                saved_stack_select <= avs_writedata[`EEU_ST_SAVED_SM];
            end
            if (bus_done && avs_write &&
                    avs_address[3:2] == `EEU_REG_SAVED_PC) begin
                saved_pc <= avs_writedata;
                ret_clear_low <= 1'b0;
            end
            if (ev != `EEU_EV_NONE) begin
                stack_select <= next_sm;
                irq_enable_bit <= next_ie;
                cond_bit <= next_c;
            end else if (take && cond_we) begin
                cond_bit <= next_c;
            end
            if (do_save) begin
                saved_stack_select <= stack_select;
                saved_irq_enable <= irq_enable_bit;
                saved_condition <= cond_bit;
                saved_pc <= next_saved_pc;
                ret_clear_low <= do_fault;
            end
        end
    end

    // Holds a break request until it is taken; a new request wins.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sbreak_pending <= 1'b0;
        end else if (system_break_event) begin
            sbreak_pending <= 1'b1;
        end else if (ev == `EEU_EV_SBREAK) begin
            sbreak_pending <= 1'b0;
        end
    end

    // ************************************************************
    // Avalon-MM slave: one wait cycle, then the answer
    // ************************************************************

    // Waitrequest drops for one cycle after each request is seen.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
            ctrl <= `EEU_CTRL_RESET;
        end else begin
            avs_waitrequest <= !(bus_req && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                case (avs_address[3:2])
                    `EEU_REG_CTRL: avs_readdata <= {30'h0, ctrl};
                    `EEU_REG_STATUS: avs_readdata <= status_rd;
                    `EEU_REG_SAVED_PC: avs_readdata <= saved_pc;
                    `EEU_REG_EVENT: avs_readdata <= {29'h0, last_event};
                    default: avs_readdata <= 32'h00000000;
                endcase
            end
            if (bus_done && avs_write &&
                    avs_address[3:2] == `EEU_REG_CTRL) begin
                ctrl <= avs_writedata[1:0];
            end
        end
    end

endmodule

// ---- eeu_core_assertions.sv ----
// Port checks for the exception, interrupt and trap entry unit.
`timescale 1ns/1ps
module eeu_chk (
    input wire sys_clk,
    input wire rst,
    input wire instr_valid,
    input wire [31:0] instr_pc,
    input wire [7:0] instr_op,
    input wire [3:0] trap_num,
    input wire [1:0] mem_addr_lo,
    input wire redirect_valid,
    input wire [31:0] redirect_pc,
    input wire flush,
    input wire commit_valid,
    input wire mem_access_en,
    input wire stack_select,
    input wire irq_enable_bit,
    input wire cond_bit,
    input wire saved_stack_select,
    input wire saved_irq_enable,
    input wire [31:0] saved_pc,
    input wire [2:0] last_event
);
    // Shared clock, reset and decode of the two fault kinds.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire tk = instr_valid && !redirect_valid;
    wire hf = instr_op != 8'h00 && instr_op < 8'h04;
    wire wd = instr_op > 8'h03 && instr_op < 8'h08;
    wire ud = tk && instr_op > 8'h0A;
    wire ms = tk && (hf ? mem_addr_lo[0] : wd && mem_addr_lo != 2'h0);
    // A jump to a vector always comes with a flush.
    sequence s_go(logic [31:0] v);
        redirect_valid && flush && redirect_pc == v;
    endsequence
    a_reset_entry: assert property ($fell(rst) |=>
        s_go(32'h0) && last_event == 3'h1) else $error("bad reset entry");
    a_undef_entry: assert property (ud |=>
        s_go(32'h20) && last_event == 3'h3) else $error("bad undef entry");
    a_align_entry: assert property (ms |=>
        s_go(32'h30) && !mem_access_en) else $error("bad align entry");
    a_trap_entry: assert property (tk && instr_op == 8'h08 |=>
        s_go(32'h40 + {$past(trap_num), 2'h0}) &&
        saved_pc == $past(instr_pc) + 32'h4) else $error("bad trap entry");
    a_fault_status: assert property (ud || ms |=>
        saved_irq_enable == $past(irq_enable_bit) && !cond_bit &&
        saved_stack_select == $past(stack_select) && !irq_enable_bit &&
        stack_select == $past(stack_select)) else $error("bad fault bits");
    a_fault_pc: assert property (ud || ms |=>
        saved_pc == $past(instr_pc)) else $error("bad fault pc");
    a_flush_pair: assert property (flush == redirect_valid)
        else $error("flush without redirect");
    a_flush_squash: assert property (redirect_valid && instr_valid
        |=> !commit_valid && !mem_access_en && !redirect_valid)
        else $error("younger instruction not squashed");
    a_irq_masked: assert property (!irq_enable_bit |=>
        !(redirect_valid && last_event == 3'h6)) else $error("masked irq");
    a_return_bits: assert property (tk && instr_op == 8'h09 |=>
        redirect_valid && stack_select == $past(saved_stack_select) &&
        irq_enable_bit == $past(saved_irq_enable)) else $error("bad return");
endmodule

// ---- eeu_pipe_model.sv ----
// Pipeline and interrupt controller model facing the entry unit.
`timescale 1ns/1ps
module eeu_pipe_model (
    input wire sys_clk,
    output reg instr_valid,
    output reg [31:0] instr_pc,
    output reg [31:0] instr_next_pc,
    output reg [7:0] instr_op,
    output reg [3:0] trap_num,
    output reg [1:0] mem_addr_lo,
    output reg cond_we,
    output reg cond_value,
    output reg system_break_event,
    output reg peripheral_irq
);
    // Everything is idle at time zero.
    initial begin
        {instr_valid, instr_pc, instr_next_pc} = 65'h0;
        {instr_op, trap_num, mem_addr_lo} = 14'h0;
        {cond_we, cond_value, system_break_event, peripheral_irq} = 4'h0;
    end
    // Shows one instruction for one edge, then scrambles its addresses.
    task issue(input [7:0] op, input [31:0] pc, input [31:0] nx,
            input [1:0] lo, input [3:0] n);
        begin
            @(posedge sys_clk);
            instr_valid <= 1'b1;
            {instr_op, trap_num, mem_addr_lo} <= {op, n, lo};
            {instr_pc, instr_next_pc} <= {pc, nx};
            @(posedge sys_clk);
            instr_valid <= 1'b0;
            {instr_pc, instr_next_pc} <= ~{pc, nx};
            #1;
        end
    endtask
    // One condition-writing alu instruction at a word boundary.
    task cond(input v);
        begin
            {cond_we, cond_value} <= {1'b1, v};
            issue(8'h00, 32'h400, 32'h404, 2'h0, 4'h0);
            cond_we <= 1'b0;
        end
    endtask
    // A given instruction at 0x500, then a younger word read right behind.
    task burst(input [7:0] op);
        begin
            @(posedge sys_clk);
            instr_valid <= 1'b1;
            {instr_op, trap_num, mem_addr_lo} <= {op, 4'h0, 2'h0};
            {instr_pc, instr_next_pc} <= {32'h500, 32'h504};
            @(posedge sys_clk);
            instr_op <= 8'h04;
            {instr_pc, instr_next_pc} <= {32'h504, 32'h508};
            @(posedge sys_clk);
            instr_valid <= 1'b0;
            #1;
        end
    endtask
    // Interrupt controller request level.
    task irq(input v);
        begin
            @(posedge sys_clk);
            peripheral_irq <= v;
        end
    endtask
    // One-cycle break pulse, already edge detected.
    task brk;
        begin
            @(posedge sys_clk);
            system_break_event <= 1'b1;
            @(posedge sys_clk);
            system_break_event <= 1'b0;
        end
    endtask
endmodule

// ---- eit_vector_exception_unit_tb.sv ----
// Self-checking bench for the exception entry unit.
`timescale 1ns/1ps
module eit_vector_exception_unit_tb;
    reg sys_clk = 1'b0;
    reg rst = 1'b1;
    reg [3:0] avs_address = 4'h0;
    reg avs_read = 1'b0;
    reg avs_write = 1'b0;
    reg [31:0] avs_writedata = 32'h0;
    reg [31:0] rd;
    reg [31:0] n;
    reg [31:0] lo;
    reg f;
    integer num_errors = 0;
    integer tests_run = 0;
    wire [31:0] avs_readdata, redirect_pc, saved_pc, instr_pc, instr_next_pc;
    wire avs_waitrequest, redirect_valid, flush, commit_valid;
    wire mem_access_en, stack_select, irq_enable_bit, cond_bit;
    wire saved_stack_select, saved_irq_enable, saved_condition;
    wire instr_valid, cond_we, cond_value, system_break_event, peripheral_irq;
    wire [2:0] last_event;
    wire [7:0] instr_op;
    wire [3:0] trap_num;
    wire [1:0] mem_addr_lo;
    eeu_core dut_u (.sys_clk, .rst, .instr_valid, .instr_pc, .instr_next_pc,
        .instr_op, .trap_num, .mem_addr_lo, .cond_we, .cond_value,
        .system_break_event, .peripheral_irq, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .redirect_valid, .redirect_pc, .flush, .commit_valid, .mem_access_en,
        .stack_select, .irq_enable_bit, .cond_bit, .saved_stack_select,
        .saved_irq_enable, .saved_condition, .saved_pc, .last_event);
    eeu_pipe_model pm_u (.sys_clk, .instr_valid, .instr_pc, .instr_next_pc,
        .instr_op, .trap_num, .mem_addr_lo, .cond_we, .cond_value,
        .system_break_event, .peripheral_irq);
    // The 40 MHz clock.
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Counts a check and reports a mismatch.
    task chk(input [31:0] got, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("[ERR] %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task print_verdict;
        begin
            $display("errors %0d checks %0d", num_errors, tests_run);
            if (num_errors == 0 && tests_run > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // One Avalon-MM access, held until waitrequest is sampled low.
    task bus(input w, input [3:0] a, input [31:0] d);
        integer i;
        begin
            @(posedge sys_clk);
            {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
            i = 0;
            @(posedge sys_clk);
            while (avs_waitrequest !== 1'b0) begin
                i = i + 1;
                if (i > 20) begin
                    num_errors = num_errors + 1;
                    print_verdict;
                end
                @(posedge sys_clk);
            end
            rd = avs_readdata;
            {avs_write, avs_read, avs_writedata} <= {2'h0, ~d};
        end
    endtask
    // Register reset values, read-only event code and read-back.
    task t_regs;
        begin
            bus(1'b0, 4'hC, 32'h0);
            chk(rd, 32'h1);
            bus(1'b0, 4'h0, 32'h0);
            chk(rd, 32'h0);
            bus(1'b1, 4'hC, 32'h7);
            bus(1'b0, 4'hC, 32'h0);
            chk(rd, 32'h1);
        end
    endtask
    // Every trap number, with stack select kept set.
    task t_traps;
        begin
            bus(1'b1, 4'h4, 32'hC1);
            for (n = 32'h0; n < 32'h10; n = n + 32'h1) begin
                pm_u.issue(8'h08, 32'h100 + 8 * n, 32'h0, 2'h0, n[3:0]);
                chk(redirect_pc, 32'h40 + 4 * n);
                chk(saved_pc, 32'h104 + 8 * n);
                chk({stack_select, irq_enable_bit, cond_bit}, 32'h4);
            end
        end
    endtask
    // Undefined opcode at a halfword address beats an irq, then return.
    task t_fault;
        begin
            bus(1'b1, 4'h4, 32'hC0);
            pm_u.cond(1'b1);
            chk(cond_bit, 32'h1);
            pm_u.irq(1'b1);
            pm_u.issue(8'hFF, 32'h6, 32'h8, 2'h0, 4'h0);
            chk(redirect_pc, 32'h20);
            chk({flush, commit_valid}, 32'h2);
            chk(saved_pc, 32'h6);
            chk({saved_stack_select, saved_irq_enable, saved_condition},
                32'h7);
            chk({stack_select, irq_enable_bit, cond_bit}, 32'h4);
            pm_u.irq(1'b0);
            pm_u.issue(8'h09, 32'h24, 32'h28, 2'h0, 4'h0);
            chk(redirect_pc, 32'h4);
            chk({stack_select, irq_enable_bit, cond_bit}, 32'h7);
            pm_u.burst(8'hFF);
            chk({commit_valid, mem_access_en, redirect_valid}, 32'h0);
            chk(saved_pc, 32'h500);
        end
    endtask
    // All load and store kinds at all four low address values.
    task t_align;
        begin
            for (n = 32'h1; n < 32'h8; n = n + 32'h1)
                for (lo = 32'h0; lo < 32'h4; lo = lo + 32'h1) begin
                    f = n < 32'h4 ? lo[0] : lo != 32'h0;
                    pm_u.issue(n[7:0], 32'h200, 32'h204, lo[1:0], 4'h0);
                    chk(redirect_valid, f);
                    chk(mem_access_en, !f);
                    chk(commit_valid, !f);
                    if (f)
                        chk(redirect_pc, 32'h30);
                end
        end
    endtask
    // Interrupt acceptance, flash relocation and system break.
    task t_irq;
        begin
            bus(1'b1, 4'h4, 32'hC0);
            pm_u.irq(1'b1);
            pm_u.issue(8'h05, 32'h300, 32'h304, 2'h2, 4'h0);
            chk(redirect_pc, 32'h30);
            bus(1'b1, 4'h4, 32'hC0);
            pm_u.issue(8'h00, 32'h300, 32'h302, 2'h0, 4'h0);
            chk(redirect_valid, 32'h0);
            chk(commit_valid, 32'h1);
            pm_u.issue(8'h00, 32'h300, 32'h304, 2'h0, 4'h0);
            chk(redirect_pc, 32'h80);
            chk(saved_pc, 32'h304);
            chk({stack_select, irq_enable_bit}, 32'h0);
            bus(1'b1, 4'h0, 32'h2);
            bus(1'b1, 4'h4, 32'h40);
            pm_u.issue(8'h00, 32'h308, 32'h30C, 2'h0, 4'h0);
            chk(redirect_pc, 32'h00804000);
            bus(1'b1, 4'h0, 32'h0);
            pm_u.brk;
            pm_u.issue(8'h00, 32'h310, 32'h314, 2'h0, 4'h0);
            chk(redirect_pc, 32'h10);
            chk(saved_pc, 32'h314);
            pm_u.irq(1'b0);
        end
    endtask
    // Reset for 16 cycles, then every scenario in turn.
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs;
        t_traps;
        t_fault;
        t_align;
        t_irq;
        print_verdict;
    end
endmodule
bind eeu_core eeu_chk chk_u (.sys_clk, .rst, .instr_valid, .instr_pc,
    .instr_op, .trap_num, .mem_addr_lo, .redirect_valid, .redirect_pc,
    .flush, .commit_valid, .mem_access_en, .stack_select, .irq_enable_bit,
    .cond_bit,
    .saved_stack_select, .saved_irq_enable, .saved_pc, .last_event);
